//--- core/acfg_top.v
// Configuration register bank for input mode, test patterns and frame clock.
// Assumes a host on the serial control port and converter data on CORE_CLK.
//
// Overview of operation
// - Bit 5 selects single-ended channel A input.
// - Fuse load returns serial-written registers to reset.
// - Constant mode outputs MSB-aligned 18-bit pattern.
// - Ramp mode steps by the pattern value.
// - Bits 7-5 choose channel B output mode.
// - Bits 4-2 choose channel A output mode.
// - Patterns precede bit mapper at native width.
// - Source bit picks converter or down-converter clock.
// - Divide bit only for 2-wire bypass/real.
// - Stretch bit spans both channels, half-wire complex.
`timescale 1ns/10ps
`include "acfg_defines.vh"

module acfg_top (
    // Clock, reset and enable.
    input  wire                        CORE_CLK,
    input  wire                        RST_B,
    input  wire                        CORE_CE,
    // Serial control port pins.
    input  wire                        SPI_SEN_B,
    input  wire                        SPI_SCLK,
    input  wire                        SPI_SDIN,
    output reg                         SPI_SDOUT,
    output reg                         SPI_SDOUT_OE,
    // Converter samples.
    input  wire                        SAMPLE_VALID,
    input  wire [`ACFG_NATIVE_W-1:0]   CONV_A,
    input  wire [`ACFG_NATIVE_W-1:0]   CONV_B,
    // Channel outputs toward the bit mapper.
    output wire [`ACFG_NATIVE_W-1:0]   CHAN_A_DATA,
    output wire [`ACFG_NATIVE_W-1:0]   CHAN_B_DATA,
    // Static configuration outputs and the one-cycle fuse load pulse.
    output reg                         CHAN_A_SINGLE_ENDED_SEL,
    output reg                         FRAME_CLOCK_SOURCE,
    output reg                         FRAME_CLOCK_DIVIDE,
    output reg                         FRAME_CLOCK_STRETCH,
    output reg                         FUSE_MAPPING_LOAD
);

    // ****************************************************************
    // Pin synchronisers and glitch filter
    // ****************************************************************
    wire [2:0] pin_raw = {SPI_SDIN, SPI_SCLK, SPI_SEN_B};
    reg  [2:0] sync1_r;
    reg  [2:0] sync2_r;
    reg  [2:0] sync3_r;
    reg  [2:0] filt_r;
    genvar gi;

    // A pin change is taken only once stages two and three agree, so a
    // single-cycle glitch on SCLK cannot clock a bit in.
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
            always @(posedge CORE_CLK) begin
                if (!RST_B) begin
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                    sync3_r[gi] <= 1'b1;
                    filt_r[gi]  <= 1'b1;
                end else if (CORE_CE) begin
                    sync1_r[gi] <= pin_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        filt_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    wire sen_b = filt_r[0];
    wire sclk  = filt_r[1];
    wire sdin  = filt_r[2];

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg                    fuse_r;
    reg  [7:0]             pat_low_r;
    reg  [7:0]             pat_mid_r;
    reg  [7:0]             pat_high_r;
    reg                    sclk_d_r;
    reg  [`ACFG_CNT_W-1:0] cnt_r;
    reg  [`ACFG_FRAME_W-1:0] shift_r;
    reg                    rd_r;
    reg  [7:0]             rd_shift_r;

    wire sclk_rise = sclk & ~sclk_d_r;
    wire sclk_fall = ~sclk & sclk_d_r;
    wire [`ACFG_ADDR_W-1:0] hdr_addr = {shift_r[`ACFG_ADDR_W-2:0], sdin};
    // After fifteen rises the read flag sits at bit 14, so the address is 13:7.
    wire [`ACFG_ADDR_W-1:0] wr_addr  = shift_r[`ACFG_FRAME_W-3:7];
    wire [7:0]              wr_data  = {shift_r[6:0], sdin};
    wire [`ACFG_PAT_W-1:0]  user_pattern_value =
        {pat_high_r[`ACFG_PAT_TOP_HI:0], pat_mid_r, pat_low_r};

    // ****************************************************************
    // Read-back multiplexer; unmapped addresses read as zero
    // ****************************************************************
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = `ACFG_RESET_BYTE;
        if (hdr_addr == `ACFG_ADDR_AIN) begin
            rd_mux[`ACFG_BIT_SE_A] = CHAN_A_SINGLE_ENDED_SEL;
        end else if (hdr_addr == `ACFG_ADDR_FUSE) begin
            rd_mux[`ACFG_BIT_FUSE_LD] = fuse_r;
        end else if (hdr_addr == `ACFG_ADDR_PAT_LOW) begin
            rd_mux = pat_low_r;
        end else if (hdr_addr == `ACFG_ADDR_PAT_MID) begin
            rd_mux = pat_mid_r;
        end else if (hdr_addr == `ACFG_ADDR_PAT_HIGH) begin
            rd_mux = pat_high_r;
        end else if (hdr_addr == `ACFG_ADDR_FRAME_CLOCK) begin
            rd_mux[`ACFG_BIT_FRAME_CLOCK_SOURCE] = FRAME_CLOCK_SOURCE;
            rd_mux[`ACFG_BIT_FRAME_CLOCK_DIVIDE] = FRAME_CLOCK_DIVIDE;
            rd_mux[`ACFG_BIT_FRAME_CLOCK_TOG] = FRAME_CLOCK_STRETCH;
        end
    end

    // ****************************************************************
    // Serial frame engine and register writes
    // ****************************************************************
    wire commit = sclk_rise & ~sen_b & (cnt_r == `ACFG_CNT_LAST) & ~rd_r;
    // Fuse load fires on the 1 -> 0 write of the load bit.
    wire fuse_fire = commit & (wr_addr == `ACFG_ADDR_FUSE) & fuse_r
                     & ~wr_data[`ACFG_BIT_FUSE_LD];

    // Frame bits shift in on SCLK rising; read data shifts out on falling.
    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            sclk_d_r     <= 1'b1;               // Matches the filter's reset level.
            cnt_r        <= `ACFG_CNT_ZERO;
            shift_r      <= {`ACFG_FRAME_W{1'b0}};
            rd_r         <= 1'b0;
            rd_shift_r   <= `ACFG_RESET_BYTE;
            SPI_SDOUT    <= 1'b0;
            SPI_SDOUT_OE <= 1'b0;
        end else if (CORE_CE) begin
            sclk_d_r <= sclk;
            if (sen_b) begin
                cnt_r        <= `ACFG_CNT_ZERO;
                rd_r         <= 1'b0;
                SPI_SDOUT_OE <= 1'b0;
            end else begin
                if (sclk_rise && cnt_r != `ACFG_CNT_DONE) begin
                    shift_r <= {shift_r[`ACFG_FRAME_W-2:0], sdin};
                    cnt_r   <= cnt_r + `ACFG_CNT_ONE;
                    if (cnt_r == `ACFG_CNT_HDR_LAST) begin
                        rd_r       <= shift_r[`ACFG_RW_POS];
                        rd_shift_r <= rd_mux;
                    end
                end
                if (sclk_fall && rd_r && cnt_r != `ACFG_CNT_DONE) begin
                    SPI_SDOUT    <= rd_shift_r[7];
                    rd_shift_r   <= {rd_shift_r[6:0], 1'b0};
                    SPI_SDOUT_OE <= 1'b1;
                end
            end
        end
    end

    // Configuration registers.  A fuse load clears every serial-written
    // setting, so anything programmed before it is lost.
    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            CHAN_A_SINGLE_ENDED_SEL <= `ACFG_RESET_BIT;
            fuse_r                  <= `ACFG_RESET_BIT;
            pat_low_r               <= `ACFG_RESET_BYTE;
            pat_mid_r               <= `ACFG_RESET_BYTE;
            pat_high_r              <= `ACFG_RESET_BYTE;
            FRAME_CLOCK_SOURCE      <= `ACFG_RESET_BIT;
            FRAME_CLOCK_DIVIDE      <= `ACFG_RESET_BIT;
            FRAME_CLOCK_STRETCH     <= `ACFG_RESET_BIT;
            FUSE_MAPPING_LOAD       <= 1'b0;
        end else if (CORE_CE) begin
            FUSE_MAPPING_LOAD <= fuse_fire;
            if (fuse_fire) begin
                CHAN_A_SINGLE_ENDED_SEL <= `ACFG_RESET_BIT;
                fuse_r                  <= `ACFG_RESET_BIT;
                pat_low_r               <= `ACFG_RESET_BYTE;
                pat_mid_r               <= `ACFG_RESET_BYTE;
                pat_high_r              <= `ACFG_RESET_BYTE;
                FRAME_CLOCK_SOURCE      <= `ACFG_RESET_BIT;
                FRAME_CLOCK_DIVIDE      <= `ACFG_RESET_BIT;
                FRAME_CLOCK_STRETCH     <= `ACFG_RESET_BIT;
            end else if (commit) begin
                if (wr_addr == `ACFG_ADDR_AIN) begin
                    CHAN_A_SINGLE_ENDED_SEL <= wr_data[`ACFG_BIT_SE_A];
                end else if (wr_addr == `ACFG_ADDR_FUSE) begin
                    fuse_r <= wr_data[`ACFG_BIT_FUSE_LD];
                end else if (wr_addr == `ACFG_ADDR_PAT_LOW) begin
                    pat_low_r <= wr_data;
                end else if (wr_addr == `ACFG_ADDR_PAT_MID) begin
                    pat_mid_r <= wr_data;
                end else if (wr_addr == `ACFG_ADDR_PAT_HIGH) begin
                    pat_high_r <= wr_data;
                end else if (wr_addr == `ACFG_ADDR_FRAME_CLOCK) begin
                    FRAME_CLOCK_SOURCE  <= wr_data[`ACFG_BIT_FRAME_CLOCK_SOURCE];
                    FRAME_CLOCK_DIVIDE  <= wr_data[`ACFG_BIT_FRAME_CLOCK_DIVIDE];
                    FRAME_CLOCK_STRETCH <= wr_data[`ACFG_BIT_FRAME_CLOCK_TOG];
                end
            end
        end
    end

    // ****************************************************************
    // Per-channel pattern generators
    // ****************************************************************
    wire [2*`ACFG_NATIVE_W-1:0] conv_all = {CONV_B, CONV_A};
    wire [2*`ACFG_NATIVE_W-1:0] data_all;
    wire [5:0] mode_all = {pat_high_r[`ACFG_PAT_B_HI:`ACFG_PAT_B_LO],
                           pat_high_r[`ACFG_PAT_A_HI:`ACFG_PAT_A_LO]};

    // Index 0 is channel A, index 1 channel B.
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
            acfg_patgen u_patgen (
                .clk          (CORE_CLK),
                .rst_b        (RST_B),
                .ce           (CORE_CE),
                .mode         (mode_all[gi*3 +: 3]),
                .pattern      (user_pattern_value),
                .sample_valid (SAMPLE_VALID),
                .conv_data    (conv_all[gi*`ACFG_NATIVE_W +: `ACFG_NATIVE_W]),
                .data_r       (data_all[gi*`ACFG_NATIVE_W +: `ACFG_NATIVE_W])
            );
        end
    endgenerate

    assign CHAN_A_DATA = data_all[`ACFG_NATIVE_W-1:0];
    assign CHAN_B_DATA = data_all[2*`ACFG_NATIVE_W-1:`ACFG_NATIVE_W];

endmodule // acfg_top

//--- core/acfg_defines.vh
// Named constants for the output test and frame clock configuration bank.
// Assumes inclusion by bare name from the core files; definitions only.
`ifndef ACFG_DEFINES_VH
`define ACFG_DEFINES_VH

// ****************************************************************
// Register addresses on the serial control port
// ****************************************************************
`define ACFG_ADDR_W        7
`define ACFG_ADDR_AIN      7'h11
`define ACFG_ADDR_FUSE     7'h13
`define ACFG_ADDR_PAT_LOW  7'h14
`define ACFG_ADDR_PAT_MID  7'h15
`define ACFG_ADDR_PAT_HIGH 7'h16
`define ACFG_ADDR_FRAME_CLOCK     7'h19

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ACFG_BIT_SE_A      5
`define ACFG_BIT_FUSE_LD   0
`define ACFG_BIT_FRAME_CLOCK_SOURCE  7
`define ACFG_BIT_FRAME_CLOCK_DIVIDE  4
`define ACFG_BIT_FRAME_CLOCK_TOG  0
`define ACFG_PAT_B_HI      7
`define ACFG_PAT_B_LO      5
`define ACFG_PAT_A_HI      4
`define ACFG_PAT_A_LO      2
`define ACFG_PAT_TOP_HI    1
`define ACFG_RESET_BYTE    8'h00
`define ACFG_RESET_BIT     1'h0

// ****************************************************************
// Pattern modes and widths
// ****************************************************************
`define ACFG_MODE_NORMAL   3'h0
`define ACFG_MODE_RAMP     3'h2
`define ACFG_MODE_CONST    3'h3
`define ACFG_PAT_W         18
`define ACFG_NATIVE_W      14
`define ACFG_PAT_ZERO      18'h00000
`define ACFG_DATA_ZERO     14'h0000

// ****************************************************************
// Serial frame layout: one read bit, seven address bits, eight data bits
// ****************************************************************
`define ACFG_FRAME_W       16
`define ACFG_CNT_W         5
`define ACFG_CNT_ZERO      5'h00
`define ACFG_CNT_ONE       5'h01
`define ACFG_CNT_HDR_LAST  5'h07
`define ACFG_CNT_LAST      5'h0f
`define ACFG_CNT_DONE      5'h10
`define ACFG_RW_POS        6

`endif

//--- core/acfg_patgen.v
// Per-channel test pattern generator placed ahead of the output bit mapper.
// Assumes conversion samples and their valid strobe arrive on CORE_CLK.
`timescale 1ns/10ps
`include "acfg_defines.vh"

module acfg_patgen (
    // Clock, reset and enable.
    input  wire                        clk,
    input  wire                        rst_b,
    input  wire                        ce,
    // Configuration.
    input  wire [2:0]                  mode,
    input  wire [`ACFG_PAT_W-1:0]      pattern,
    // Converter data in and channel data out.
    input  wire                        sample_valid,
    input  wire [`ACFG_NATIVE_W-1:0]   conv_data,
    output reg  [`ACFG_NATIVE_W-1:0]   data_r
);

    // ****************************************************************
    // Ramp accumulator and output selection
    // ****************************************************************
    reg  [`ACFG_PAT_W-1:0] ramp_r;
    wire [`ACFG_PAT_W-1:0] ramp_nxt = ramp_r + pattern;

    // The ramp runs in the full 18-bit space so the increment lines up
    // with the MSB-aligned pattern field; the top bits are the native word.
    always @(posedge clk) begin
        if (!rst_b) begin
            ramp_r <= `ACFG_PAT_ZERO;
            data_r <= `ACFG_DATA_ZERO;
        end else if (ce) begin
            if (mode != `ACFG_MODE_RAMP) begin
                ramp_r <= `ACFG_PAT_ZERO;
            end else if (sample_valid) begin
                ramp_r <= ramp_nxt;
            end
            if (sample_valid) begin
                case (mode)
                    `ACFG_MODE_RAMP: begin
                        data_r <= ramp_r[`ACFG_PAT_W-1 -: `ACFG_NATIVE_W];
                    end
                    `ACFG_MODE_CONST: begin
                        data_r <= pattern[`ACFG_PAT_W-1 -: `ACFG_NATIVE_W];
                    end
                    default: begin
                        data_r <= conv_data;
                    end
                endcase
            end
        end
    end

endmodule // acfg_patgen

//--- testbench/acfg_host.sv
// Host model driving the serial control port of the configuration bank.
// Assumes CORE_CLK as timing base; SCLK rests low between frames.
`timescale 1ns/10ps
module acfg_host (
    // Timing base.
    input  wire clk,
    // Serial control port.
    output reg  sen_b,
    output reg  sclk,
    output reg  sdin,
    input  wire sdout
);
    // Idle levels; SCLK stands still outside frames.
    initial begin
        sen_b = 1'b1;
        sclk = 1'b0;
        sdin = 1'b0;
    end

    // One 16-bit frame, MSB first; phases of 8 cycles clear the pin filter.
    task frame(input rd, input [6:0] addr, input [7:0] wdat, output [7:0] rdat);
        reg [15:0] word;
        integer i;
        begin
            word = {rd, addr, wdat};
            rdat = 8'h00;
            @(posedge clk);
            #1 sen_b = 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                repeat (4) @(posedge clk);
                #1 sdin = word[i];
                repeat (4) @(posedge clk);
                #1 sclk = 1'b1;
                repeat (8) @(posedge clk);
                #1 rdat[i % 8] = (i < 8) ? sdout : 1'b0;
                sclk = 1'b0;
            end
            repeat (8) @(posedge clk);
            #1 sen_b = 1'b1;
            // A released data line must not keep showing its last bit.
            sdin = ~sdin;
            repeat (8) @(posedge clk);
        end
    endtask
endmodule // acfg_host

//--- testbench/acfg_checker.sv
// Assertions on the pins of the configuration bank top module.
// Assumes host SCLK phases of at least 8 cycles; frozen cycles are excluded from the pass-through checks only.
`timescale 1ns/10ps
`include "acfg_defines.vh"
module acfg_checker (
    // Clock, reset and enable.
    input wire                      CORE_CLK,
    input wire                      RST_B,
    input wire                      CORE_CE,
    // Serial pins.
    input wire                      SPI_SEN_B,
    input wire                      SPI_SCLK,
    input wire                      SPI_SDIN,
    input wire                      SPI_SDOUT,
    input wire                      SPI_SDOUT_OE,
    // Samples and channel data.
    input wire                      SAMPLE_VALID,
    input wire [`ACFG_NATIVE_W-1:0] CONV_A,
    input wire [`ACFG_NATIVE_W-1:0] CONV_B,
    input wire [`ACFG_NATIVE_W-1:0] CHAN_A_DATA,
    input wire [`ACFG_NATIVE_W-1:0] CHAN_B_DATA,
    // Static configuration and the fuse load pulse.
    input wire                      CHAN_A_SINGLE_ENDED_SEL,
    input wire                      FRAME_CLOCK_SOURCE,
    input wire                      FRAME_CLOCK_DIVIDE,
    input wire                      FRAME_CLOCK_STRETCH,
    input wire                      FUSE_MAPPING_LOAD
);
    reg        dflt_r;
    wire [3:0] cfg = {CHAN_A_SINGLE_ENDED_SEL, FRAME_CLOCK_SOURCE,
                      FRAME_CLOCK_DIVIDE, FRAME_CLOCK_STRETCH};
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);

    // Modes are known to be normal after reset or a fuse load, until a new frame starts.
    always @(posedge CORE_CLK) begin
        if (!RST_B || FUSE_MAPPING_LOAD) begin
            dflt_r <= 1'b1;
        end else if ($fell(SPI_SEN_B)) begin
            dflt_r <= 1'b0;
        end
    end
    sequence s_plain_sample;
        dflt_r && SAMPLE_VALID && CORE_CE;
    endsequence

    // ********
    // Properties
    // ********
    fuse_single_a: assert property (FUSE_MAPPING_LOAD |=> !FUSE_MAPPING_LOAD)
        else $error("fuse load pulse lasts more than one cycle");
    fuse_clears_a: assert property (FUSE_MAPPING_LOAD |=> cfg == 4'h0)
        else $error("configuration not cleared by fuse load");
    fuse_in_frame_a: assert property (FUSE_MAPPING_LOAD |-> !SPI_SEN_B)
        else $error("fuse load outside a frame");
    cfg_hold_a: assert property (SPI_SEN_B [*8] |-> $stable(cfg))
        else $error("configuration changed with no frame");
    chan_hold_a: assert property (!$past(SAMPLE_VALID) |-> $stable({CHAN_A_DATA, CHAN_B_DATA}))
        else $error("channel data changed without a sample");
    chan_a_pass_a: assert property (s_plain_sample |=> CHAN_A_DATA == $past(CONV_A))
        else $error("channel A not passing converter data");
    chan_b_pass_a: assert property (s_plain_sample |=> CHAN_B_DATA == $past(CONV_B))
        else $error("channel B not passing converter data");
    oe_idle_a: assert property (SPI_SEN_B [*8] |-> !SPI_SDOUT_OE)
        else $error("read data driven while deselected");
    oe_rise_a: assert property ($rose(SPI_SDOUT_OE) |-> !SPI_SEN_B)
        else $error("read driver enabled while deselected");
endmodule // acfg_checker

bind acfg_top acfg_checker acfg_checker_inst (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CORE_CE(CORE_CE), .SPI_SEN_B(SPI_SEN_B),
    .SPI_SCLK(SPI_SCLK), .SPI_SDIN(SPI_SDIN), .SPI_SDOUT(SPI_SDOUT),
    .SPI_SDOUT_OE(SPI_SDOUT_OE), .SAMPLE_VALID(SAMPLE_VALID), .CONV_A(CONV_A),
    .CONV_B(CONV_B), .CHAN_A_DATA(CHAN_A_DATA), .CHAN_B_DATA(CHAN_B_DATA),
    .CHAN_A_SINGLE_ENDED_SEL(CHAN_A_SINGLE_ENDED_SEL), .FRAME_CLOCK_SOURCE(FRAME_CLOCK_SOURCE),
    .FRAME_CLOCK_DIVIDE(FRAME_CLOCK_DIVIDE), .FRAME_CLOCK_STRETCH(FRAME_CLOCK_STRETCH),
    .FUSE_MAPPING_LOAD(FUSE_MAPPING_LOAD)
);

//--- testbench/acfg_top_test.sv
// Self-checking bench: register, test pattern, frame clock and fuse load scenarios.
// Assumes the host model drives the serial pins; CORE_CE drops only in t_hold.
`timescale 1ns/10ps
`include "acfg_defines.vh"
module acfg_top_test;
    reg                       core_clk, rst_b, sample_valid, core_ce;
    reg  [`ACFG_NATIVE_W-1:0] conv_a, conv_b;
    wire [`ACFG_NATIVE_W-1:0] chan_a, chan_b;
    wire                      sen_b, sclk, sdin, sdout, sdout_oe;
    wire                      se_sel, fc_src, fc_div, fc_str, fuse_ld;
    reg  [7:0]                rd, pulses;
    integer                   errors, n_compared, cycles;

    acfg_top acfg_top_inst (
        .CORE_CLK(core_clk), .RST_B(rst_b), .CORE_CE(core_ce), .SPI_SEN_B(sen_b),
        .SPI_SCLK(sclk), .SPI_SDIN(sdin), .SPI_SDOUT(sdout), .SPI_SDOUT_OE(sdout_oe),
        .SAMPLE_VALID(sample_valid), .CONV_A(conv_a), .CONV_B(conv_b),
        .CHAN_A_DATA(chan_a), .CHAN_B_DATA(chan_b), .CHAN_A_SINGLE_ENDED_SEL(se_sel),
        .FRAME_CLOCK_SOURCE(fc_src), .FRAME_CLOCK_DIVIDE(fc_div),
        .FRAME_CLOCK_STRETCH(fc_str), .FUSE_MAPPING_LOAD(fuse_ld)
    );
    acfg_host acfg_host_inst (.clk(core_clk), .sen_b(sen_b), .sclk(sclk), .sdin(sdin),
        .sdout(sdout));

    // Clock, fuse pulse counter and hang guard.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (fuse_ld === 1'b1) pulses <= pulses + 8'h01;
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: timeout", $time);
            close_out;
        end
    end

    // ********
    // Shared tasks
    // ********
    task close_out;
        begin
            if (errors == 0 && n_compared > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task compare_byte(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task compare_word(input [`ACFG_NATIVE_W-1:0] got, input [`ACFG_NATIVE_W-1:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED at %0t: data %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        acfg_host_inst.frame(1'b0, a, d, rd);
    endtask
    task rdchk(input [6:0] a, input [7:0] exp);
        begin
            acfg_host_inst.frame(1'b1, a, 8'h00, rd);
            compare_byte(rd, exp);
        end
    endtask
    task flags(input [3:0] exp);
        compare_byte({4'h0, se_sel, fc_src, fc_div, fc_str}, {4'h0, exp});
    endtask
    // One sample strobe; inputs show inverted values once no longer sampled.
    task sample(input [13:0] a, input [13:0] b, input [13:0] ea, input [13:0] eb);
        begin
            @(posedge core_clk);
            #1 sample_valid = 1'b1;
            conv_a = a;
            conv_b = b;
            @(posedge core_clk);
            #1 sample_valid = 1'b0;
            conv_a = ~a;
            conv_b = ~b;
            compare_word(chan_a, ea);
            compare_word(chan_b, eb);
        end
    endtask
    task all_zero;
        begin
            rdchk(`ACFG_ADDR_AIN, 8'h00);
            rdchk(`ACFG_ADDR_FUSE, 8'h00);
            rdchk(`ACFG_ADDR_PAT_LOW, 8'h00);
            rdchk(`ACFG_ADDR_PAT_MID, 8'h00);
            rdchk(`ACFG_ADDR_PAT_HIGH, 8'h00);
            rdchk(`ACFG_ADDR_FRAME_CLOCK, 8'h00);
        end
    endtask

    // ********
    // Scenarios
    // ********
    task t_reset;
        begin
            flags(4'h0);
            sample(14'h1234, 14'h0abc, 14'h1234, 14'h0abc);
            all_zero;
            rdchk(7'h12, 8'h00);
        end
    endtask
    task t_fuse;
        reg [7:0] p0;
        begin
            p0 = pulses;
            wr(`ACFG_ADDR_FUSE, 8'h01);
            rdchk(`ACFG_ADDR_FUSE, 8'h01);
            compare_byte(pulses - p0, 8'h00);
            wr(`ACFG_ADDR_FUSE, 8'h00);
            compare_byte(pulses - p0, 8'h01);
            flags(4'h0);
            all_zero;
            sample(14'h2d2d, 14'h1e1e, 14'h2d2d, 14'h1e1e);
        end
    endtask
    task t_input;
        begin
            wr(`ACFG_ADDR_AIN, 8'hff);
            flags(4'h8);
            rdchk(`ACFG_ADDR_AIN, 8'h20);
        end
    endtask
    // With the clock enable low a sample strobe must leave the outputs alone.
    task t_hold;
        begin
            sample(14'h0f0f, 14'h0707, 14'h0f0f, 14'h0707);
            core_ce = 1'b0;
            sample(14'h0101, 14'h0202, 14'h0f0f, 14'h0707);
            core_ce = 1'b1;
            flags(4'h8);
        end
    endtask
    task t_frame_clock;
        reg [31:0] tab;
        integer i;
        begin
            tab = 32'h10018000;
            for (i = 0; i < 4; i = i + 1) begin
                wr(`ACFG_ADDR_FRAME_CLOCK, tab[8*i +: 8]);
                flags({1'b1, tab[8*i+7], tab[8*i+4], tab[8*i]});
            end
        end
    endtask
    task t_const;
        begin
            wr(`ACFG_ADDR_PAT_LOW, 8'hcd);
            wr(`ACFG_ADDR_PAT_MID, 8'hbc);
            wr(`ACFG_ADDR_PAT_HIGH, 8'h6e);
            rdchk(`ACFG_ADDR_PAT_HIGH, 8'h6e);
            sample(14'h0111, 14'h0222, 14'h2bcc, 14'h2bcc);
            sample(14'h0333, 14'h0444, 14'h2bcc, 14'h2bcc);
        end
    endtask
    task t_ramp;
        integer i;
        begin
            wr(`ACFG_ADDR_PAT_LOW, 8'h10);
            wr(`ACFG_ADDR_PAT_MID, 8'h00);
            wr(`ACFG_ADDR_PAT_HIGH, 8'h68);
            for (i = 0; i < 4; i = i + 1) begin
                sample(14'h0111, 14'h0222, i[13:0], 14'h0001);
            end
            wr(`ACFG_ADDR_PAT_HIGH, 8'h20);
            sample(14'h0555, 14'h0666, 14'h0555, 14'h0666);
            wr(`ACFG_ADDR_PAT_HIGH, 8'h68);
            sample(14'h0111, 14'h0222, 14'h0000, 14'h0001);
        end
    endtask

    // Main sequence: fuse load comes before any other configuration write.
    initial begin
        rst_b = 1'b0;
        core_ce = 1'b1;
        sample_valid = 1'b0;
        conv_a = 14'h0000;
        conv_b = 14'h0000;
        pulses = 8'h00;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge core_clk);
        t_reset;
        t_fuse;
        t_input;
        t_hold;
        t_frame_clock;
        t_const;
        t_ramp;
        t_fuse;
        close_out;
    end
endmodule // acfg_top_test
